// ### sdl_core.sv
/*
  sdl_core: modulator configuration and lock detect register bank with
  a classic wishbone slave, seed staging, autocal trigger and interrupt.
  assumes one clock (the phase detector reference) and a synchronous reset.
*/
// Our own choice: the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
module sdl_core (
    // clock and reset
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    // wishbone slave
    input  wire logic               cyc_i,
    input  wire logic               stb_i,
    input  wire logic               we_i,
    input  wire logic [7:0]         adr_i,
    input  wire logic [3:0]         sel_i,
    input  wire logic [31:0]        dat_i,
    output logic [31:0]             dat_o,
    output logic                    ack_o,
    // modulator side
    input  wire logic [3:0]         mod_step_i,
    output logic [3:0]              div_step_o,
    output logic                    modulator_path_skip_o,
    output logic                    fractional_core_on_o,
    output logic                    mod_clk_en_o,
    output logic [23:0]             seed_value_o,
    output logic                    seed_load_o,
    output logic                    autocal_start_o,
    output logic [18:0]             int_div_o,
    output logic [23:0]             frac_div_o,
    // lock detector side
    input  wire sdl_pkg::sdl_cmp_t  cmp_i,
    output logic                    lock_o,
    // interrupt
    output logic                    irq_o
);
    import sdl_pkg::*;

    // ========================================================
    // helpers
    function automatic logic [23:0] seed_of(input logic [1:0] c);
        case (c)
            2'h0:    seed_of = SDL_SEED_ZERO;
            2'h1:    seed_of = SDL_SEED_LSB;
            2'h2:    seed_of = SDL_SEED_A;
            default: seed_of = SDL_SEED_B;
        endcase
    endfunction : seed_of

    function automatic logic [23:0] merge(input logic [23:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  sel);
        logic [23:0] r;
        r = old;
        if (sel[0]) r[7:0]   = wd[7:0];
        if (sel[1]) r[15:8]  = wd[15:8];
        if (sel[2]) r[23:16] = wd[23:16];
        merge = r;
    endfunction : merge

    // ========================================================
    // state
    typedef struct packed {
        logic [23:0]        int_div;
        logic [23:0]        frac_div;
        logic [23:0]        vco_spi;
        logic [23:0]        mod_cfg;
        logic [23:0]        lock_ctl;
        logic [SDL_EV_W-1:0] status;
        logic [SDL_EV_W-1:0] mask;
        logic               armed;
        logic [23:0]        seed;
        logic               seed_load;
        logic               autocal;
        logic [3:0]         div_step;
        logic               lock_prev;
        logic               ack;
        logic [31:0]        rdat;
        logic               irq;
    } sdl_core_st_t;

    sdl_core_st_t st_q;
    sdl_core_st_t st_d;

    logic       locked;
    logic       req;
    logic       wr;
    logic [5:0] idx;

    assign req = cyc_i && stb_i && !st_q.ack;
    assign wr  = req && we_i;
    assign idx = adr_i[7:2];

    // ========================================================
    // lock detector
    sdl_lock_det u_lock (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .enable_i (st_q.lock_ctl[SDL_LCK_ON]),
        .code_i   (st_q.lock_ctl[SDL_LCK_THR_HI:SDL_LCK_THR_LO]),
        .cmp_i    (cmp_i),
        .locked_o (locked)
    );

    // ========================================================
    // next state
    always_comb begin
        logic                trig;
        logic [SDL_EV_W-1:0] ev;
        logic [SDL_EV_W-1:0] clr;
        logic [23:0]         vco_new;
        trig    = 1'b0;
        ev      = '0;
        clr     = '0;
        vco_new = '0;
        st_d    = st_q;

        st_d.ack       = req;
        st_d.seed_load = 1'b0;
        st_d.autocal   = 1'b0;

        // register writes merge byte lanes; int_div and vco_spi bits above their widths are cleared
        if (wr) begin
            case (idx)
                SDL_IDX_INT_DIV: begin
                    st_d.int_div = merge(st_q.int_div, dat_i, sel_i);
                    st_d.int_div[23:SDL_INT_DIV_W] = '0;
                    trig = !st_q.mod_cfg[SDL_MOD_CORE_ON];
                end
                SDL_IDX_FRAC_DIV: begin
                    st_d.frac_div = merge(st_q.frac_div, dat_i, sel_i);
                    trig = st_q.mod_cfg[SDL_MOD_CORE_ON];
                end
                SDL_IDX_VCO_SPI: begin
                    vco_new = merge(st_q.vco_spi, dat_i, sel_i);
                    vco_new[23:SDL_VCO_SPI_W] = '0;
                    st_d.vco_spi = vco_new;
                    st_d.armed = (vco_new[SDL_VCO_ADR_HI:0] == 7'h00);
                end
                SDL_IDX_MOD_CFG: begin
                    st_d.mod_cfg = merge(st_q.mod_cfg, dat_i, sel_i);
                end
                SDL_IDX_LOCK_CTL: begin
                    st_d.lock_ctl = merge(st_q.lock_ctl, dat_i, sel_i);
                end
                SDL_IDX_STATUS: begin
                    if (sel_i[0]) clr = dat_i[SDL_EV_W-1:0];
                end
                SDL_IDX_MASK: begin
                    if (sel_i[0]) st_d.mask = dat_i[SDL_EV_W-1:0];
                end
                default: begin
                end
            endcase
        end

        // frequency change: trigger write, autocal only once armed
        if (trig) begin
            if (st_q.armed) begin
                st_d.autocal = 1'b1;
                ev[SDL_EV_AUTOCAL] = 1'b1;
            end
            if (st_q.mod_cfg[SDL_MOD_SEED_LOAD]) begin
                st_d.seed = seed_of(st_q.mod_cfg[SDL_MOD_SEED_HI:SDL_MOD_SEED_LO]);
                st_d.seed_load = 1'b1;
                ev[SDL_EV_SEED] = 1'b1;
            end
        end

        // divider ignores modulator output while bypassed
        if (st_q.mod_cfg[SDL_MOD_SKIP]) begin
            st_d.div_step = 4'h0;
        end else begin
            st_d.div_step = mod_step_i;
        end

        // lock events
        st_d.lock_prev = locked;
        ev[SDL_EV_LOCKED] = locked && !st_q.lock_prev;
        ev[SDL_EV_UNLOCK] = !locked && st_q.lock_prev;

        // sticky status, set wins over clear
        st_d.status = (st_q.status & ~clr) | ev;
        st_d.irq    = |(st_d.status & st_d.mask);

        // read data
        st_d.rdat = '0;
        if (req && !we_i) begin
            case (idx)
                SDL_IDX_INT_DIV:  st_d.rdat = {8'h00, st_q.int_div};
                SDL_IDX_FRAC_DIV: st_d.rdat = {8'h00, st_q.frac_div};
                SDL_IDX_VCO_SPI:  st_d.rdat = {8'h00, st_q.vco_spi};
                SDL_IDX_MOD_CFG:  st_d.rdat = {8'h00, st_q.mod_cfg};
                SDL_IDX_LOCK_CTL: st_d.rdat = {8'h00, st_q.lock_ctl};
                SDL_IDX_STATUS:   st_d.rdat = {28'h000_0000, st_q.status};
                SDL_IDX_MASK:     st_d.rdat = {28'h000_0000, st_q.mask};
                SDL_IDX_STATE:    st_d.rdat = {30'h0000_0000, st_q.armed, locked};
                default:          st_d.rdat = '0;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q          <= '0;
            st_q.int_div  <= SDL_RST_INT_DIV;
            st_q.frac_div <= SDL_RST_FRAC_DIV;
            st_q.vco_spi  <= SDL_RST_VCO_SPI;
            st_q.mod_cfg  <= SDL_RST_MOD_CFG;
            st_q.lock_ctl <= SDL_RST_LOCK_CTL;
        end else begin
            st_q <= st_d;
        end
    end

    // ========================================================
    // outputs
    assign dat_o                 = st_q.rdat;
    assign ack_o                 = st_q.ack;
    assign div_step_o            = st_q.div_step;
    assign modulator_path_skip_o = st_q.mod_cfg[SDL_MOD_SKIP];
    assign fractional_core_on_o  = st_q.mod_cfg[SDL_MOD_CORE_ON];
    assign mod_clk_en_o          = st_q.mod_cfg[SDL_MOD_CORE_ON];
    assign seed_value_o          = st_q.seed;
    assign seed_load_o           = st_q.seed_load;
    assign autocal_start_o       = st_q.autocal;
    assign int_div_o             = st_q.int_div[SDL_INT_DIV_W-1:0];
    assign frac_div_o            = st_q.frac_div;
    assign lock_o                = locked;
    assign irq_o                 = st_q.irq;

endmodule : sdl_core
`default_nettype wire

// ### sdl_pkg.sv
/*
  sdl_pkg: register map, field positions, reset values and shared types
  for the modulator configuration and lock detector block.
  assumes a 32-bit classic wishbone slave with word-aligned registers.
*/
package sdl_pkg;

    // ========================================================
    // register indices (byte address = 4 * index)
    localparam logic [5:0] SDL_IDX_INT_DIV  = 6'h03;
    localparam logic [5:0] SDL_IDX_FRAC_DIV = 6'h04;
    localparam logic [5:0] SDL_IDX_VCO_SPI  = 6'h05;
    localparam logic [5:0] SDL_IDX_MOD_CFG  = 6'h06;
    localparam logic [5:0] SDL_IDX_LOCK_CTL = 6'h07;
    localparam logic [5:0] SDL_IDX_STATUS   = 6'h10;
    localparam logic [5:0] SDL_IDX_MASK     = 6'h11;
    localparam logic [5:0] SDL_IDX_STATE    = 6'h12;

    // ========================================================
    // reset values
    localparam logic [23:0] SDL_RST_INT_DIV  = 24'h00_0019;
    localparam logic [23:0] SDL_RST_FRAC_DIV = 24'h00_0000;
    localparam logic [23:0] SDL_RST_VCO_SPI  = 24'h00_0000;
    localparam logic [23:0] SDL_RST_MOD_CFG  = 24'h20_0b4a;
    localparam logic [23:0] SDL_RST_LOCK_CTL = 24'h00_014d;

    // ========================================================
    // field positions
    localparam int SDL_MOD_SEED_LO   = 0;
    localparam int SDL_MOD_SEED_HI   = 1;
    localparam int SDL_MOD_SKIP      = 7;
    localparam int SDL_MOD_SEED_LOAD = 8;
    localparam int SDL_MOD_CORE_ON   = 11;
    localparam int SDL_LCK_THR_LO    = 0;
    localparam int SDL_LCK_THR_HI    = 2;
    localparam int SDL_LCK_ON        = 3;
    localparam int SDL_VCO_ADR_HI    = 6;
    localparam int SDL_INT_DIV_W     = 19;
    localparam int SDL_VCO_SPI_W     = 16;

    // status / mask bits
    localparam int SDL_EV_LOCKED  = 0;
    localparam int SDL_EV_UNLOCK  = 1;
    localparam int SDL_EV_AUTOCAL = 2;
    localparam int SDL_EV_SEED    = 3;
    localparam int SDL_EV_W       = 4;

    // ========================================================
    // seed values
    localparam logic [23:0] SDL_SEED_ZERO = 24'h00_0000;
    localparam logic [23:0] SDL_SEED_LSB  = 24'h00_0001;
    localparam logic [23:0] SDL_SEED_A    = 24'hb2_9d08;
    localparam logic [23:0] SDL_SEED_B    = 24'h50_f1cd;

    // consecutive in-window thresholds
    localparam int SDL_CNT_W = 17;
    localparam logic [16:0] SDL_THR_0 = 17'h0_0005;
    localparam logic [16:0] SDL_THR_1 = 17'h0_0020;
    localparam logic [16:0] SDL_THR_2 = 17'h0_0060;
    localparam logic [16:0] SDL_THR_3 = 17'h0_0100;
    localparam logic [16:0] SDL_THR_4 = 17'h0_0200;
    localparam logic [16:0] SDL_THR_5 = 17'h0_0800;
    localparam logic [16:0] SDL_THR_6 = 17'h0_2000;
    localparam logic [16:0] SDL_THR_7 = 17'h0_ffff;

    // ========================================================
    // types
    typedef struct packed {
        logic valid;
        logic in_window;
    } sdl_cmp_t;

    typedef struct packed {
        logic [16:0] count;
        logic        locked;
    } sdl_lock_st_t;

endpackage : sdl_pkg

// ### sdl_lock_det.sv
/*
  sdl_lock_det: consecutive in-window comparison counter and lock flag.
  assumes comparison results arrive on clk_i as one-cycle valid pulses.
*/
`timescale 1ns/1ns
`default_nettype none
module sdl_lock_det (
    // clock and reset
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    // control
    input  wire logic               enable_i,
    input  wire logic [2:0]         code_i,
    input  wire sdl_pkg::sdl_cmp_t  cmp_i,
    // result
    output logic                    locked_o
);
    import sdl_pkg::*;

    // ========================================================
    // threshold decode
    function automatic logic [16:0] thr_of(input logic [2:0] c);
        case (c)
            3'h0:    thr_of = SDL_THR_0;
            3'h1:    thr_of = SDL_THR_1;
            3'h2:    thr_of = SDL_THR_2;
            3'h3:    thr_of = SDL_THR_3;
            3'h4:    thr_of = SDL_THR_4;
            3'h5:    thr_of = SDL_THR_5;
            3'h6:    thr_of = SDL_THR_6;
            default: thr_of = SDL_THR_7;
        endcase
    endfunction : thr_of

    // ========================================================
    // state
    sdl_lock_st_t st_q;
    sdl_lock_st_t st_d;

    always_comb begin
        st_d = st_q;
        if (!enable_i) begin
            st_d.count  = '0;
            st_d.locked = 1'b0;
        end else if (cmp_i.valid) begin
            if (!cmp_i.in_window) begin
                st_d.count  = '0;
                st_d.locked = 1'b0;
            end else if (st_q.count < thr_of(code_i)) begin
                st_d.count = st_q.count + 17'h0_0001;
                if (st_d.count >= thr_of(code_i)) begin
                    st_d.locked = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign locked_o = st_q.locked;

endmodule : sdl_lock_det
`default_nettype wire

// ### sdl_core_checker.sv
/* port assertions for sdl_core.
   assumes a bind into sdl_core; one clock, sync reset. */
`timescale 1ns/1ns
`default_nettype none
module sdl_core_checker (
    // clock and reset
    input wire logic              clk_i,
    input wire logic              rst_i,
    // bus
    input wire logic              cyc_i,
    input wire logic              stb_i,
    input wire logic              ack_o,
    // modulator
    input wire logic [3:0]        mod_step_i,
    input wire logic [3:0]        div_step_o,
    input wire logic              modulator_path_skip_o,
    input wire logic              fractional_core_on_o,
    input wire logic              mod_clk_en_o,
    input wire logic [23:0]       seed_value_o,
    input wire logic              seed_load_o,
    input wire logic              autocal_start_o,
    // lock
    input wire sdl_pkg::sdl_cmp_t cmp_i,
    input wire logic              lock_o
);
    import sdl_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ==================================================
    // bus and modulator
    sequence s_take; cyc_i && stb_i && !ack_o; endsequence
    sequence s_answer; ack_o ##1 !ack_o; endsequence
    a_bus_answer: assert property (s_take |=> s_answer) else $error("bad ack");
    a_skip_zero: assert property (modulator_path_skip_o && $past(modulator_path_skip_o)
        |-> div_step_o == 4'h0) else $error("bypassed step not zero");
    a_skip_pass: assert property (!modulator_path_skip_o && $past(!modulator_path_skip_o)
        && $past(!rst_i) |-> div_step_o == $past(mod_step_i)) else $error("step not passed");
    a_clock_gate: assert property (mod_clk_en_o == fractional_core_on_o) else $error("clock gate");
    a_seed_table: assert property (seed_load_o |-> seed_value_o inside
        {24'h00_0000, 24'h00_0001, 24'hb2_9d08, 24'h50_f1cd}) else $error("bad seed");
    a_pulse_on_ack: assert property ((autocal_start_o || seed_load_o) |->
        ack_o ##1 !(autocal_start_o || seed_load_o)) else $error("stray pulse");
    // ==================================================
    // lock
    a_lock_drop: assert property (cmp_i.valid && !cmp_i.in_window |=> !lock_o) else $error("lock kept");
    a_lock_cause: assert property ($rose(lock_o) |->
        $past(cmp_i.valid && cmp_i.in_window)) else $error("lock without comparison");
endmodule : sdl_core_checker
`default_nettype wire

// ### sdl_host_model.sv
/* host stand-in issuing classic wishbone cycles.
   assumes the bench calls xfer one request at a time. */
`timescale 1ns/1ns
`default_nettype none
module sdl_host_model (
    // clock
    input  wire logic        clk_i,
    // wishbone master
    output logic             cyc_o,
    output logic             stb_o,
    output logic             we_o,
    output logic [7:0]       adr_o,
    output logic [3:0]       sel_o,
    output logic [31:0]      dat_o,
    input  wire logic [31:0] dat_i,
    input  wire logic        ack_i
);
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o = 1'b0;
        adr_o = 8'h00;
        sel_o = 4'hf;
        dat_o = 32'h0000_0000;
    end
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= w;
        adr_o <= a;
        dat_o <= d;
        @(posedge clk_i);
        while (ack_i !== 1'b1) @(posedge clk_i);
        q = dat_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        dat_o <= ~d;
    endtask : xfer
endmodule : sdl_host_model
`default_nettype wire

// ### tb_sigma_delta_and_lock_config.sv
/* self-checking bench for sdl_core.
   assumes sdl_host_model as bus master and the bound checker. */
`timescale 1ns/1ns
`default_nettype none
module tb_sigma_delta_and_lock_config;
    import sdl_pkg::*;
    logic        clk_i, rst_i, cyc, stb, we, ack, skip, core_on, clk_en, ld, cal, lock, irq, armed;
    logic [7:0]  adr;
    logic [3:0]  sel, mstep;
    logic [31:0] wdat, rdat, q, v;
    logic [23:0] seed_o, seen_seed, e_seed, fdiv;
    logic [18:0] idiv;
    sdl_cmp_t    cmp;
    int          fail_count, checked, cal_n, ld_n, e_cal, e_ld;
    int          thr [8] = '{5, 32, 96, 256, 512, 2048, 8192, 65535};
    logic [23:0] seeds [4] = '{24'h00_0000, 24'h00_0001, 24'hb2_9d08, 24'h50_f1cd};
    sdl_host_model host (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
        .sel_o(sel), .dat_o(wdat), .dat_i(rdat), .ack_i(ack));
    sdl_core dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .mod_step_i(mstep), .div_step_o(),
        .modulator_path_skip_o(skip), .fractional_core_on_o(core_on), .mod_clk_en_o(clk_en),
        .seed_value_o(seed_o), .seed_load_o(ld), .autocal_start_o(cal), .int_div_o(idiv), .frac_div_o(fdiv),
        .cmp_i(cmp), .lock_o(lock), .irq_o(irq));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        mstep <= 4'($urandom);
        if (cal === 1'b1) cal_n++;
        if (ld === 1'b1) seen_seed = seed_o;
        if (ld === 1'b1) ld_n++;
    end
    // ==================================================
    // tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        host.xfer(1'b0, a, 32'h0000_0000, q);
        chk(q, exp);
    endtask : rd
    task automatic trig(input logic [7:0] a);
        logic        hit;
        logic [31:0] d;
        hit = (a == 8'h10) == v[11];
        d = $urandom & 32'h00ff_ffff;
        wr(a, d);
        if (hit && armed) e_cal++;
        if (hit && v[8]) e_seed = seeds[v[1:0]];
        if (hit && v[8]) e_ld++;
        repeat (2) @(negedge clk_i);
        chk(cal_n, e_cal);
        chk(ld_n, e_ld);
        chk(32'(seen_seed), 32'(e_seed));
        chk(a == 8'h0c ? 32'(idiv) : 32'(fdiv), a == 8'h0c ? d & 32'h0007_ffff : d);
    endtask : trig
    task automatic pulses(input int n, input logic w);
        repeat (n) @(posedge clk_i) begin
            cmp.valid <= 1'b1;
            cmp.in_window <= w;
        end
        @(posedge clk_i) cmp.valid <= 1'b0;
        @(negedge clk_i);
    endtask : pulses
    task automatic close_out;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : close_out
    // ==================================================
    // sequence
    initial begin
        #950_000;
        fail_count++;
        close_out();
    end
    initial begin
        rst_i = 1'b1;
        cmp = '0;
        armed = 1'b0;
        e_seed = 24'h00_0000;
        void'($urandom(32'hd5a2_3f7c));
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(8'h18, 32'h0020_0b4a);
        rd(8'h1c, 32'h0000_014d);
        rd(8'h3c, 32'h0000_0000);
        chk(32'({skip, core_on, clk_en}), 32'h0000_0003);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            wr(8'h14, $urandom & 32'h0000_ff80);
            armed = 1'b1;
            v = ($urandom & 32'h00ff_f07c) | 32'h0000_0700 | 32'(i % 4) | 32'((i % 2) << 7) | 32'((i / 4) << 11);
            wr(8'h18, v);
            rd(8'h18, v);
            trig(v[11] ? 8'h0c : 8'h10);
            trig(v[11] ? 8'h10 : 8'h0c);
            chk(32'({skip, core_on, clk_en}), 32'({v[7], v[11], v[11]}));
        end
        rd(8'h48, 32'h0000_0002);
        wr(8'h14, 32'h0000_0001);
        armed = 1'b0;
        rd(8'h48, 32'h0000_0000);
        v = 32'h0000_0603;
        wr(8'h18, v);
        trig(8'h0c);
        $display("test seed and autocal done");
        rd(8'h40, 32'h0000_000c);
        chk(32'(irq), 32'h0000_0000);
        wr(8'h44, 32'h0000_0004);
        repeat (2) @(negedge clk_i);
        chk(32'(irq), 32'h0000_0001);
        wr(8'h40, 32'h0000_0004);
        repeat (2) @(negedge clk_i);
        chk(32'(irq), 32'h0000_0000);
        rd(8'h40, 32'h0000_0008);
        $display("test interrupt done");
        for (int k = 0; k < 8; k++) begin
            wr(8'h1c, ($urandom & 32'h00ff_fff0) | 32'h0000_0008 | 32'(k));
            pulses(1, 1'b0);
            pulses(thr[k] - 1, 1'b1);
            chk(32'(lock), 32'h0000_0000);
            pulses(1, 1'b1);
            chk(32'(lock), 32'h0000_0001);
            pulses(1, 1'b0);
            chk(32'(lock), 32'h0000_0000);
        end
        wr(8'h1c, 32'h0000_0000);
        pulses(8, 1'b1);
        chk(32'(lock), 32'h0000_0000);
        rd(8'h40, 32'h0000_000b);
        $display("test lock done");
        close_out();
    end
endmodule : tb_sigma_delta_and_lock_config
bind sdl_core sdl_core_checker u_checker (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .ack_o(ack_o), .mod_step_i(mod_step_i), .div_step_o(div_step_o),
    .modulator_path_skip_o(modulator_path_skip_o), .fractional_core_on_o(fractional_core_on_o),
    .mod_clk_en_o(mod_clk_en_o), .seed_value_o(seed_value_o), .seed_load_o(seed_load_o),
    .autocal_start_o(autocal_start_o), .cmp_i(cmp_i), .lock_o(lock_o));
`default_nettype wire
